// [rtl/test_dac_defines.vh]
// Register map, field positions, reset values and timing figures of the test converter.
// Included by the converter top and its sigma-delta core; definitions only.
`ifndef TEST_DAC_DEFINES_VH
`define TEST_DAC_DEFINES_VH

// Clock rate
`define REF_CLK_PERIOD_NS      40
`define REF_CLK_MHZ            25

// Register indexes on the plain port
`define ADDR_W                 4
`define REG_TEST_MODE          4'h0
`define REG_OFFSET_GAIN        4'h1
`define REG_CLOCK_CTRL         4'h2
`define REG_STATUS             4'h3

// Test-mode word fields
`define TEST_MODE_LSB          14
`define TEST_MODE_MSB          17
`define TEST_MODE_PLAIN        4'h7
`define TEST_MODE_OFFSET       4'hA
`define TEST_MODE_RESET        32'h00000000
`define TEST_MODE_PLAIN_WORD   32'h0001C00C

// Offset removal and signal gain fields
`define OFFSET_LSB             16
`define OFFSET_MSB             27
`define GAIN_LSB               28
`define GAIN_MSB               31
`define OFFSET_GAIN_RESET      32'h00000000
// One offset step is full scale / 4096, full scale is 32768 counts
`define OFFSET_SHIFT           3

// Clock control fields
`define DEMOD_DIV_LSB          0
`define DEMOD_DIV_MSB          7
`define RECOV_DIV_LSB          8
`define RECOV_DIV_MSB          15
`define DEMOD_SEL_BIT          16
`define CLOCK_CTRL_RESET       32'h00000102

// Sigma-delta full-scale levels and error limit
`define SD_POS_LEVEL           24'h007FFF
`define SD_NEG_LEVEL           24'hFF8000
`define SD_ERR_LIMIT           24'h040000

`endif

// [rtl/clock_div_tick.v]
// Divides a tick stream by a programmable ratio, one output tick per N input ticks.
// Assumes tick_in comes from logic on the same clock; a ratio of zero acts as one.
`timescale 1ns/1ps

module clock_div_tick #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  // Tick stream and ratio
  input  wire         tick_in,
  input  wire [W-1:0] divide,
  output wire         tick_out
);

  reg  [W-1:0] cnt_r;
  wire [W-1:0] limit;

  // Ratio zero behaves as ratio one
  assign limit    = (divide == {W{1'b0}}) ? {W{1'b0}} : divide - {{(W-1){1'b0}}, 1'b1};
  assign tick_out = tick_in && (cnt_r >= limit);

  // Count input ticks, wrap at the limit
  always @(posedge clk)
  begin
    if (rst)
      cnt_r <= {W{1'b0}};
    else if (tick_in)
    begin
      if (cnt_r >= limit)
        cnt_r <= {W{1'b0}};
      else
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // clock_div_tick

// [rtl/sigma_delta_mod2.v]
// Second-order error-feedback sigma-delta modulator with a one-bit quantizer.
// Assumes step pulses once per converter clock and data_in holds between steps.
`timescale 1ns/1ps
`include "test_dac_defines.vh"

module sigma_delta_mod2 (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Converter clock strobe and enable
  input  wire        step,
  input  wire        enable,
  // Signed sample in, bit stream out
  input  wire [15:0] data_in,
  output reg         bit_out
);

  reg  signed [23:0] err1_r;
  reg  signed [23:0] err2_r;
  wire signed [23:0] x_ext;
  wire signed [23:0] v;
  wire signed [23:0] q;
  wire signed [23:0] e_raw;
  wire signed [23:0] e_sat;

  // Quantizer input: x - 2 e[n-1] + e[n-2], noise shaped by (1 - z^-1)^2
  assign x_ext = {{8{data_in[15]}}, data_in};
  assign v     = x_ext - (err1_r <<< 1) + err2_r;
  assign q     = v[23] ? `SD_NEG_LEVEL : `SD_POS_LEVEL;
  assign e_raw = q - v;
  // Bound the error so an overloaded input cannot run the loop away
  assign e_sat = (e_raw > $signed(`SD_ERR_LIMIT)) ? $signed(`SD_ERR_LIMIT) :
                 (e_raw < -$signed(`SD_ERR_LIMIT)) ? -$signed(`SD_ERR_LIMIT) : e_raw;

  // Sign of quantizer input, error fed back through both stages
  always @(posedge clk)
  begin
    if (rst)
    begin
      err1_r  <= 24'h000000;
      err2_r  <= 24'h000000;
      bit_out <= 1'b0;
    end
    else if (!enable)
    begin
      err1_r  <= 24'h000000;
      err2_r  <= 24'h000000;
      bit_out <= 1'b0;
    end
    else if (step)
    begin
      bit_out <= ~v[23]; // RQ12
      err1_r  <= e_sat;  // RQ12
      err2_r  <= err1_r; // RQ1
    end
  end

endmodule // sigma_delta_mod2

// [rtl/test_dac_top.v]
// Demodulator test converter: offset/gain stage, sigma-delta modulator, output pin mux.
// Assumes filter outputs come from logic on ref_clk and the host uses the plain register port.
//
// What this block does
// RQ1 - 16-bit filter result to second-order bit stream
// RQ2 - Bit stream drives clock output pin when enabled
// RQ3 - Modulator on recovery clock, filters on demodulator clock
// RQ4 - Recovery clock at demod rate disables recovery
// RQ5 - Test mode 7 enables converter, no offset
// RQ6 - Test mode 10 enables converter with offset
// RQ7 - Active demodulator's filter output feeds converter
// RQ8 - Input is (signal - offset/4096) times 2^gain
// RQ9 - Removable offset limited to magnitude 1.0
// RQ10 - Host programs half the frequency error
// RQ11 - Demod clock = crystal/div, recovery = demod/div
// RQ12 - Two error states, sign output, error fed back
`timescale 1ns/1ps
`include "test_dac_defines.vh"

module test_dac_top #(
  parameter DIV_W = 8
) (
  // Clock and reset
  input  wire                ref_clk,
  input  wire                rst,
  // Register port
  input  wire [`ADDR_W-1:0]  addr,
  input  wire [31:0]         wdata,
  input  wire                wr_en,
  input  wire                rd_en,
  output reg  [31:0]         rdata,
  // Post-demodulator filter outputs
  input  wire [15:0]         linear_filter_out,
  input  wire [15:0]         correlator_filter_out,
  // Normal clock output source
  input  wire                normal_clock_out,
  // Pin and status outputs
  output wire                clock_output_pin,
  output wire                demod_tick,
  output wire                recovery_tick,
  output wire                recovery_active,
  output wire                converter_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  ////////////////////////////////////////////////////////////////////////////

  reg  [31:0] test_mode_r;
  reg  [31:0] offset_gain_r;
  reg  [31:0] clock_ctrl_r;
  reg  [15:0] conv_in_r;
  reg         pin_r;

  wire [3:0]       test_mode;
  wire [11:0]      offset_field;
  wire [3:0]       gain_field;
  wire [DIV_W-1:0] demod_div;
  wire [DIV_W-1:0] recovery_clock_divider;
  wire             demod_sel;
  wire             offset_en;
  wire             sd_bit;

  // Field extraction
  assign test_mode              = test_mode_r[`TEST_MODE_MSB:`TEST_MODE_LSB];
  assign offset_field           = offset_gain_r[`OFFSET_MSB:`OFFSET_LSB];
  assign gain_field             = offset_gain_r[`GAIN_MSB:`GAIN_LSB];
  assign demod_div              = clock_ctrl_r[`DEMOD_DIV_LSB+DIV_W-1:`DEMOD_DIV_LSB];
  assign recovery_clock_divider = clock_ctrl_r[`RECOV_DIV_LSB+DIV_W-1:`RECOV_DIV_LSB];
  assign demod_sel              = clock_ctrl_r[`DEMOD_SEL_BIT];

  // Mode decode
  assign converter_enable = (test_mode == `TEST_MODE_PLAIN) ||  // RQ5
                            (test_mode == `TEST_MODE_OFFSET);   // RQ6
  assign offset_en        = (test_mode == `TEST_MODE_OFFSET);   // RQ6

  // Register writes
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      test_mode_r   <= `TEST_MODE_RESET;
      offset_gain_r <= `OFFSET_GAIN_RESET;
      clock_ctrl_r  <= `CLOCK_CTRL_RESET;
    end
    else if (wr_en)
    begin
      case (addr)
        `REG_TEST_MODE:   test_mode_r   <= wdata;
        `REG_OFFSET_GAIN: offset_gain_r <= wdata; // RQ10
        `REG_CLOCK_CTRL:  clock_ctrl_r  <= wdata;
        default:          test_mode_r   <= test_mode_r;
      endcase
    end
  end

  // Register reads, data one cycle after the strobe
  always @(posedge ref_clk)
  begin
    if (rst)
      rdata <= 32'h00000000;
    else if (rd_en)
    begin
      case (addr)
        `REG_TEST_MODE:  rdata <= test_mode_r;
        `REG_CLOCK_CTRL: rdata <= clock_ctrl_r;
        `REG_STATUS:     rdata <= {conv_in_r, 12'h000, pin_r, recovery_active, offset_en, converter_enable};
        default:         rdata <= 32'h00000000; // Offset/gain is write-only
      endcase
    end
    else
      rdata <= 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock strobes
  ////////////////////////////////////////////////////////////////////////////

  // Demodulator rate from the crystal clock
  clock_div_tick #(.W(DIV_W)) u_demod_div (
    .clk      (ref_clk),
    .rst      (rst),
    .tick_in  (1'b1),
    .divide   (demod_div),
    .tick_out (demod_tick)   // RQ11
  );

  // Recovery rate from the demodulator rate
  clock_div_tick #(.W(DIV_W)) u_recovery_div (
    .clk      (ref_clk),
    .rst      (rst),
    .tick_in  (demod_tick),
    .divide   (recovery_clock_divider),
    .tick_out (recovery_tick) // RQ11
  );

  // Recovery stops when its clock reaches the demodulator rate
  assign recovery_active = (recovery_clock_divider > {{(DIV_W-1){1'b0}}, 1'b1}); // RQ4

  ////////////////////////////////////////////////////////////////////////////
  // Offset removal and gain, demodulator rate
  ////////////////////////////////////////////////////////////////////////////

  wire signed [15:0] filt_sel;
  wire signed [17:0] offset_counts;
  wire signed [17:0] diff;
  wire signed [33:0] gained;
  wire               sat_hi;
  wire               sat_lo;

  // Active demodulator's filter feeds the converter
  assign filt_sel      = demod_sel ? correlator_filter_out : linear_filter_out; // RQ7
  // Offset scaled to counts; 12-bit field keeps it below 1.0 of full scale
  assign offset_counts = offset_en ? $signed({3'b000, offset_field, 3'b000}) : 18'sd0; // RQ9
  assign diff          = {{2{filt_sel[15]}}, filt_sel} - offset_counts;                // RQ8
  assign gained        = {{16{diff[17]}}, diff} <<< gain_field;                        // RQ8
  assign sat_hi        = !gained[33] && (gained[32:15] != 18'h00000);
  assign sat_lo        = gained[33] && (gained[32:15] != 18'h3FFFF);

  // Sample once per demodulator clock, saturate to 16 bits
  always @(posedge ref_clk)
  begin
    if (rst)
      conv_in_r <= 16'h0000;
    else if (demod_tick) // RQ3
    begin
      if (sat_hi)
        conv_in_r <= 16'h7FFF;
      else if (sat_lo)
        conv_in_r <= 16'h8000;
      else
        conv_in_r <= gained[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulator at recovery rate, pin registered every clock
  ////////////////////////////////////////////////////////////////////////////

  sigma_delta_mod2 u_sd (
    .clk     (ref_clk),
    .rst     (rst),
    .step    (recovery_tick), // RQ3
    .enable  (converter_enable),
    .data_in (conv_in_r),     // RQ1
    .bit_out (sd_bit)
  );

  // Pin carries the bit stream in test mode, else the normal clock
  always @(posedge ref_clk)
  begin
    if (rst)
      pin_r <= 1'b0;
    else
      pin_r <= converter_enable ? sd_bit : normal_clock_out; // RQ2
  end

  assign clock_output_pin = pin_r;

endmodule // test_dac_top

// [dv/test_dac_checker.sv]
// Port checker for the test converter top.
// Assumes it is bound to test_dac_top and sees only its ports.
`timescale 1ns/1ps
`include "test_dac_defines.vh"

module test_dac_checker (
  // Clock and reset
  input logic               ref_clk,
  input logic               rst,
  // Register port
  input logic [`ADDR_W-1:0] addr,
  input logic [31:0]        wdata,
  input logic               wr_en,
  input logic               rd_en,
  input logic [31:0]        rdata,
  // Pin and status
  input logic               normal_clock_out,
  input logic               clock_output_pin,
  input logic               demod_tick,
  input logic               recovery_tick,
  input logic               recovery_active,
  input logic               converter_enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Register write and read steps
  sequence s_mode_wr; wr_en && addr == `REG_TEST_MODE; endsequence
  sequence s_ctrl_wr; wr_en && addr == `REG_CLOCK_CTRL; endsequence
  sequence s_ctrl_rd; rd_en && addr == `REG_CLOCK_CTRL; endsequence
  a_idle_rdata_zero: assert property (!rd_en |=> rdata == 32'h00000000)
    else $error("read data not zero");
  a_wo_read_zero: assert property (rd_en && addr == `REG_OFFSET_GAIN |=> rdata == 32'h00000000)
    else $error("write-only register read back");
  a_mode_enable: assert property (s_mode_wr ##0 (wdata[17:14] == 4'h7 || wdata[17:14] == 4'hA)
    |=> converter_enable) else $error("converter not enabled");
  a_ctrl_readback: assert property (s_ctrl_wr ##2 s_ctrl_rd |=> rdata[16:0] == $past(wdata[16:0], 3))
    else $error("clock control readback wrong");
  a_recovery_off: assert property (s_ctrl_wr |=> recovery_active == ($past(wdata[15:8]) > 8'h01))
    else $error("recovery active wrong");
  a_tick_subset: assert property (recovery_tick |-> demod_tick)
    else $error("recovery tick outside demod tick");
  a_pin_normal: assert property (!converter_enable |=> clock_output_pin == $past(normal_clock_out))
    else $error("pin not normal clock when disabled");
  a_pin_hold: assert property (converter_enable ##1 (converter_enable && !recovery_tick) ##1 converter_enable
    |=> $stable(clock_output_pin)) else $error("pin moved without recovery tick");
endmodule // test_dac_checker

bind test_dac_top test_dac_checker chk_u (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .normal_clock_out(normal_clock_out),
  .clock_output_pin(clock_output_pin), .demod_tick(demod_tick), .recovery_tick(recovery_tick),
  .recovery_active(recovery_active), .converter_enable(converter_enable));

// [dv/pin_meter.sv]
// Measurement model on the output pin: tallies bits at each strobe.
// Assumes the strobe marks one modulator bit; the bench drives clear.
`timescale 1ns/1ps

module pin_meter (
  // Clock and control
  input  logic        ref_clk,
  input  logic        clear,
  // Pin and bit strobe
  input  logic        pin,
  input  logic        strobe,
  // Tallies
  output logic [15:0] ones,
  output logic [15:0] bits
);
  // Count set bits and strobes
  always @(posedge ref_clk)
  begin
    if (clear)
    begin
      ones <= 16'h0000;
      bits <= 16'h0000;
    end
    else if (strobe)
    begin
      ones <= ones + {15'h0000, pin};
      bits <= bits + 16'h0001;
    end
  end
endmodule // pin_meter

// [dv/test_test_dac_top.sv]
// Bench for the test converter: registers, sample path, bit density.
// Assumes design, checker and pin meter are compiled first.
`timescale 1ns/1ps
`include "test_dac_defines.vh"

module test_test_dac_top;
  logic               ref_clk, rst, wr_en, rd_en, nclk, clr, pin, dtick, rtick, ract, cen;
  logic [`ADDR_W-1:0] addr;
  logic [31:0]        wdata, rdata, got;
  logic [15:0]        lin, cor, ones, bits;
  int                 num_errors, cmp_count;

  test_dac_top dut_u (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .linear_filter_out(lin), .correlator_filter_out(cor),
    .normal_clock_out(nclk), .clock_output_pin(pin), .demod_tick(dtick), .recovery_tick(rtick),
    .recovery_active(ract), .converter_enable(cen));
  pin_meter meter_u (.ref_clk(ref_clk), .clear(clr), .pin(pin), .strobe(rtick), .ones(ones), .bits(bits));

  // Clock and normal pin source
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) nclk <= ~nclk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    begin
      cmp_count++;
      if (g !== e)
      begin
        num_errors++;
        $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    begin
      @(posedge ref_clk);
      addr <= a; wdata <= d; wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
    end
  endtask

  task automatic rd(input logic [3:0] a);
    begin
      @(posedge ref_clk);
      addr <= a; rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 got = rdata;
    end
  endtask

  // Expected converter input from signal, offset, gain
  function automatic logic [15:0] conv(input int s, input int off, input int g, input bit use_off);
    int v;
    begin
      v = (use_off ? s - (off << `OFFSET_SHIFT) : s) * (1 << g);
      if (v > 32767) v = 32767;
      if (v < -32768) v = -32768;
      conv = v[15:0];
    end
  endfunction

  task automatic run_case(input logic [3:0] m, input bit sel, input logic [11:0] off, input logic [3:0] g);
    begin
      wr(`REG_OFFSET_GAIN, {g, off, 16'h0000});
      wr(`REG_CLOCK_CTRL, {15'h0000, sel, 16'h0102});
      wr(`REG_TEST_MODE, {14'h0000, m, 14'h000C});
      repeat (8) @(posedge ref_clk);
      rd(`REG_STATUS);
      chk({16'h0000, got[31:16]}, {16'h0000, conv(sel ? $signed(cor) : $signed(lin), off, g, m == 4'hA)});
      chk({29'h0, got[2:0]}, {29'h0, 1'b0, m == 4'hA, 1'b1});
    end
  endtask

  task automatic complete_run;
    begin
      $display("Errors %0d, comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // Watchdog
  initial
  begin
    #200000;
    num_errors++;
    complete_run;
  end

  // Main sequence
  initial
  begin
    rst = 1'b1; wr_en = 1'b0; rd_en = 1'b0; addr = 4'h0; wdata = 32'h00000000;
    nclk = 1'b0; clr = 1'b0; lin = 16'h1000; cor = 16'h0400; num_errors = 0; cmp_count = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`REG_CLOCK_CTRL); chk(got, `CLOCK_CTRL_RESET);
    chk({31'h0, ract}, 32'h0);
    chk({31'h0, cen}, 32'h0);
    rd(`REG_OFFSET_GAIN); chk(got, 32'h0);
    rd(4'h5); chk(got, 32'h0);
    run_case(4'h7, 1'b0, 12'h100, 4'h0);
    rd(`REG_TEST_MODE); chk(got, `TEST_MODE_PLAIN_WORD);
    run_case(4'hA, 1'b0, 12'h100, 4'h1);
    run_case(4'hA, 1'b1, 12'h100, 4'h1);
    run_case(4'hA, 1'b0, 12'h100, 4'h4);
    lin <= 16'h7FFF;
    run_case(4'hA, 1'b0, 12'hFFF, 4'h0);
    lin <= 16'h4000;
    run_case(4'h7, 1'b0, 12'h000, 4'h0);
    @(posedge ref_clk) clr <= 1'b1;
    @(posedge ref_clk) clr <= 1'b0;
    repeat (400) @(posedge ref_clk);
    #1 chk({16'h0, bits}, 32'd200);
    chk({31'h0, ones >= 16'd140 && ones <= 16'd160}, 32'h1);
    wr(`REG_TEST_MODE, 32'h0); #1 chk({31'h0, cen}, 32'h0);
    repeat (4) @(posedge ref_clk);
    wr(`REG_CLOCK_CTRL, 32'h00000402); rd(`REG_CLOCK_CTRL); chk(got, 32'h00000402);
    chk({31'h0, ract}, 32'h1);
    complete_run;
  end
endmodule // test_test_dac_top
